// ===== shared/mxu_pkg.sv
// constants, opcode set and register map of the instruction execute unit
// assumes a single 50 MHz clock domain and an apb master on the register side
`default_nettype none
package mxu_pkg;
  // timing: one instruction cycle is four system clocks
  localparam int unsigned CLK_HZ       = 50_000_000;
  localparam int unsigned TICK_CLKS    = 4;
  localparam logic [1:0]  TICK_LAST    = 2'(TICK_CLKS - 1);
  // sizes
  localparam int unsigned MEM_WORDS    = 64;
  localparam int unsigned STACK_DEPTH  = 4;
  localparam logic [9:0]  INT_VECTOR   = 10'h004;
  // apb byte offsets
  localparam logic [7:0]  OFS_INSTR    = 8'h00;
  localparam logic [7:0]  OFS_ACC      = 8'h04;
  localparam logic [7:0]  OFS_FLAGS    = 8'h08;
  localparam logic [7:0]  OFS_PC       = 8'h0c;
  localparam logic [7:0]  OFS_MADDR    = 8'h10;
  localparam logic [7:0]  OFS_MDATA    = 8'h14;
  localparam logic [7:0]  OFS_STATUS   = 8'h18;
  localparam logic [7:0]  OFS_STACK    = 8'h1c;
  // instruction word fields
  localparam int unsigned INS_OPD_LSB  = 0;   // [7:0] memory address or immediate
  localparam int unsigned INS_TGT_LSB  = 8;   // [17:8] jump target
  localparam int unsigned INS_OP_LSB   = 24;  // [28:24] opcode
  // flag register bit positions
  localparam int unsigned FL_C         = 0;
  localparam int unsigned FL_AC        = 1;
  localparam int unsigned FL_Z         = 2;
  localparam int unsigned FL_PDF       = 3;
  localparam int unsigned FL_TO        = 4;
  localparam int unsigned FL_EMI       = 5;
  // reset values
  localparam logic [7:0]  ACC_RST      = 8'h00;
  localparam logic [9:0]  PC_RST       = 10'h000;
  localparam logic [5:0]  FLAGS_RST    = 6'h00;

  typedef enum logic [4:0] {
    OP_NOP       = 5'h00, OP_CPL_M  = 5'h01, OP_CPL_A  = 5'h02, OP_DAA    = 5'h03,
    OP_DEC_M     = 5'h04, OP_DEC_A  = 5'h05, OP_INC_M  = 5'h06, OP_INC_A  = 5'h07,
    OP_JUMP      = 5'h08, OP_MOV_AM = 5'h09, OP_MOV_AX = 5'h0a, OP_MOV_MA = 5'h0b,
    OP_OR_AM     = 5'h0c, OP_OR_AX  = 5'h0d, OP_OR_M   = 5'h0e, OP_RET    = 5'h0f,
    OP_RET_AX    = 5'h10, OP_IRET   = 5'h11, OP_ROL_M  = 5'h12, OP_ROL_A  = 5'h13,
    OP_ROLC_M    = 5'h14, OP_ROLC_A = 5'h15, OP_ROR_M  = 5'h16, OP_ROR_A  = 5'h17,
    OP_RORC_M    = 5'h18, OP_RORC_A = 5'h19, OP_PWRDN  = 5'h1a
  } mxu_op_t;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_EXEC   = 2'b01,
    ST_DUMMY  = 2'b10,
    ST_HALTED = 2'b11
  } mxu_state_t;
endpackage
`default_nettype wire

// ===== verif/mxu_exec_unit_properties.sv
// port-level checker of the instruction execute unit
// assumes it is bound onto mxu_exec_unit and sees only its ports
`default_nettype none
module mxu_exec_chk
(
  input wire logic        clk_i,
  input wire logic        resetn_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        int_pending_i,
  input wire logic        wake_i,
  input wire logic        clk_run_o,
  input wire logic        wdt_clear_o,
  input wire logic        int_ack_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // accepted instruction writes and their opcode field
  wire logic       wr_ins = psel_i && penable_i && pready_o && pwrite_i && !pslverr_o
                            && paddr_i == mxu_pkg::OFS_INSTR;
  wire logic [4:0] op_w   = pwdata_i[28:24];
  wire logic       wr_acc = psel_i && penable_i && pready_o && pwrite_i;

  a_ready_zero_wait: assert property (psel_i && !penable_i |=> pready_o)
    else $error("no ready after setup");
  a_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0)
    else $error("read data not zero when idle");
  a_pdown_clk_off: assert property (wr_ins && op_w == 5'h1a |-> ##[1:6] !clk_run_o)
    else $error("clock not gated after power-down");
  a_pdown_wdt_clr: assert property (wr_ins && op_w == 5'h1a |-> ##[1:6] wdt_clear_o)
    else $error("watchdog not cleared at power-down");
  a_wdt_pulse_once: assert property (wdt_clear_o |=> !wdt_clear_o)
    else $error("watchdog clear longer than one cycle");
  a_halt_refuse_wr: assert property (!clk_run_o && !wake_i && wr_acc |-> pslverr_o)
    else $error("write accepted while halted");
  a_halt_stays: assert property (!clk_run_o && !wake_i |=> !clk_run_o)
    else $error("left power-down without wake");
  a_iret_ack: assert property (wr_ins && op_w == 5'h11 && int_pending_i
                               |-> ##[1:6] int_ack_o)
    else $error("pending interrupt not taken at return");
  a_ack_needs_req: assert property (int_ack_o |-> $past(int_pending_i))
    else $error("interrupt taken without request");
endmodule
`default_nettype wire

// ===== verif/mxu_exec_unit_tb_top.sv
// self-checking bench of the execute unit, driven over apb
// assumes the package and the checker are compiled before this file
`default_nettype none
module mxu_exec_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic             clk_i = 1'b0;
  logic             resetn_i = 1'b0;
  logic             psel_i = 1'b0;
  logic             penable_i = 1'b0;
  logic             pwrite_i = 1'b0;
  logic [7:0]       paddr_i = 8'h00;
  logic [31:0]      pwdata_i = 32'h0;
  logic             int_pending_i = 1'b0;
  logic             wake_i = 1'b0;
  wire logic [31:0] prdata_o;
  wire logic        pready_o;
  wire logic        pslverr_o;
  wire logic        clk_run_o;
  wire logic        wdt_clear_o;
  wire logic        int_ack_o;
  int               failures = 0;
  int               samples_checked = 0;
  int               cycles = 0;
  logic [15:0]      rnd = 16'h0025;
  logic [31:0]      rd;
  logic             err;
  logic             dmy;
  int               wdt_pulses = 0;
  int               ack_pulses = 0;

  mxu_exec_unit dut_u (.clk_i, .resetn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .int_pending_i, .wake_i, .clk_run_o,
    .wdt_clear_o, .int_ack_o);

  always #10 clk_i = ~clk_i;

  // one-cycle side pulses are counted so the bench can compare them
  always @(posedge clk_i)
  begin
    if (wdt_clear_o === 1'b1)
      wdt_pulses++;
    if (int_ack_o === 1'b1)
      ack_pulses++;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    for (int i = 0; i < 8; i++)
      x = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    return x;
  endfunction

  // expected {acc, mem, flags} after one data instruction
  function automatic logic [21:0] model(input logic [4:0] op, input logic [7:0] a,
    input logic [7:0] m, input logic [5:0] f, input logic [7:0] x);
    logic [7:0] r;
    logic [8:0] s;
    logic       zu;
    r = m;
    zu = 1'b1;
    case (op)
      5'h01, 5'h02: r = ~m;
      5'h04, 5'h05: r = m - 8'h01;
      5'h06, 5'h07: r = m + 8'h01;
      5'h0c, 5'h0e: r = a | m;
      5'h0d: r = a | x;
      default: zu = 1'b0;
    endcase
    case (op)
      5'h03:
      begin
        s = {1'b0, a} + {1'b0, (a[7:4] > 4'h9 || f[0]) ? 4'h6 : 4'h0,
                         (a[3:0] > 4'h9 || f[1]) ? 4'h6 : 4'h0};
        r = s[7:0];
        f[0] = (a[7:4] > 4'h9) || f[0] || s[8];
      end
      5'h09: r = m;
      5'h0a: r = x;
      5'h0b: r = a;
      5'h12, 5'h13: r = {m[6:0], m[7]};
      5'h16, 5'h17: r = {m[0], m[7:1]};
      5'h14, 5'h15:
      begin
        r = {m[6:0], f[0]};
        f[0] = m[7];
      end
      5'h18, 5'h19:
      begin
        r = {f[0], m[7:1]};
        f[0] = m[0];
      end
      default: ;
    endcase
    if (zu)
      f[2] = (r == 8'h00);
    if (op inside {5'h01, 5'h03, 5'h04, 5'h06, 5'h0b, 5'h0e, 5'h12, 5'h14, 5'h16, 5'h18})
      m = r;
    else if (op != 5'h00)
      a = r;
    return {a, m, f};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      failures++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // one apb transfer; request held until ready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  // start an instruction and poll until idle or halted, noting any dummy cycle
  task automatic exec(input logic [4:0] op, input logic [17:0] arg);
    apb(1'b1, mxu_pkg::OFS_INSTR, {3'h0, op, 6'h0, arg});
    dmy = 1'b0;
    do
    begin
      apb(1'b0, mxu_pkg::OFS_STATUS, 32'h0);
      if (rd[1:0] === 2'h2)
        dmy = 1'b1;
    end while (rd[1:0] !== 2'h0 && rd[1:0] !== 2'h3);
  endtask

  // a hang is cut short well beyond the expected run length
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      failures++;
      final_report();
    end
  end

  initial
  begin
    logic [7:0]  a;
    logic [7:0]  m;
    logic [7:0]  x;
    logic [5:0]  ad;
    logic [5:0]  f;
    logic [9:0]  pc;
    logic [21:0] e;
    repeat (4) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    // data instructions with random operands, corner values first
    for (int op = 0; op < 26; op++)
      if (!(op inside {8, 15, 16, 17}))
        for (int t = 0; t < 4; t++)
        begin
          rnd = lfsr(rnd);
          a = (t == 0) ? 8'h9a : (t == 1) ? 8'h00 : rnd[7:0];
          m = (t == 0) ? 8'hff : (t == 1) ? 8'h01 : rnd[15:8];
          rnd = lfsr(rnd);
          f = rnd[5:0];
          ad = rnd[13:8];
          x = rnd[7:0] ^ rnd[15:8];
          apb(1'b1, mxu_pkg::OFS_MADDR, {26'h0, ad});
          apb(1'b1, mxu_pkg::OFS_MDATA, {24'h0, m});
          apb(1'b1, mxu_pkg::OFS_ACC, {24'h0, a});
          apb(1'b1, mxu_pkg::OFS_FLAGS, {26'h0, f});
          apb(1'b0, mxu_pkg::OFS_PC, 32'h0);
          pc = rd[9:0];
          e = model(op[4:0], a, m, f, x);
          exec(op[4:0], {10'h0, (op inside {10, 13}) ? x : {2'b00, ad}});
          check({31'h0, dmy}, 32'h0);
          apb(1'b0, mxu_pkg::OFS_ACC, 32'h0);
          check(rd, {24'h0, e[21:14]});
          apb(1'b0, mxu_pkg::OFS_MDATA, 32'h0);
          check(rd, {24'h0, e[13:6]});
          apb(1'b0, mxu_pkg::OFS_FLAGS, 32'h0);
          check(rd, {26'h0, e[5:0]});
          apb(1'b0, mxu_pkg::OFS_PC, 32'h0);
          check(rd, {22'h0, pc + 10'h1});
        end
    // jump to a random target
    rnd = lfsr(rnd);
    exec(5'h08, {rnd[9:0], 8'h00});
    check({31'h0, dmy}, 32'h1);
    apb(1'b0, mxu_pkg::OFS_PC, 32'h0);
    check(rd, {22'h0, rnd[9:0]});
    apb(1'b0, mxu_pkg::OFS_FLAGS, 32'h0);
    check(rd, {26'h0, e[5:0]});
    // return, return with load, interrupt return without and with a pending request
    for (int k = 0; k < 4; k++)
    begin
      rnd = lfsr(rnd);
      apb(1'b1, mxu_pkg::OFS_FLAGS, 32'h0);
      apb(1'b1, mxu_pkg::OFS_STACK, {22'h0, rnd[9:0]});
      int_pending_i <= (k == 3);
      exec((k == 0) ? 5'h0f : (k == 1) ? 5'h10 : 5'h11, {10'h0, rnd[15:8]});
      check({31'h0, dmy}, 32'h1);
      apb(1'b0, mxu_pkg::OFS_PC, 32'h0);
      check(rd, {22'h0, (k == 3) ? mxu_pkg::INT_VECTOR : rnd[9:0]});
      apb(1'b0, mxu_pkg::OFS_FLAGS, 32'h0);
      check(rd, {26'h0, (k == 2) ? 6'h20 : 6'h00});
      apb(1'b0, mxu_pkg::OFS_STACK, 32'h0);
      check(rd, (k == 3) ? 32'h1 : 32'h0);
      apb(1'b0, mxu_pkg::OFS_ACC, 32'h0);
      if (k == 1)
        check(rd, {24'h0, rnd[15:8]});
      int_pending_i <= 1'b0;
    end
    check(ack_pulses, 32'h1);
    // power-down with time-out flag set, refused write, then wake
    apb(1'b1, mxu_pkg::OFS_FLAGS, 32'h10);
    apb(1'b1, mxu_pkg::OFS_ACC, 32'h5a);
    exec(5'h1a, 18'h0);
    apb(1'b0, mxu_pkg::OFS_STATUS, 32'h0);
    check(rd, 32'h3);
    apb(1'b1, mxu_pkg::OFS_ACC, 32'h0);
    check({31'h0, err}, 32'h1);
    wake_i <= 1'b1;
    do @(posedge clk_i); while (clk_run_o !== 1'b1);
    wake_i <= 1'b0;
    check(wdt_pulses, 32'h1);
    apb(1'b0, mxu_pkg::OFS_FLAGS, 32'h0);
    check(rd, 32'h08);
    apb(1'b0, mxu_pkg::OFS_ACC, 32'h0);
    check(rd, 32'h5a);
    apb(1'b0, mxu_pkg::OFS_MDATA, 32'h0);
    check(rd, {24'h0, e[13:6]});
    // refused accesses: unmapped, read-only, unknown opcode
    apb(1'b0, 8'h20, 32'h0);
    check({31'h0, err}, 32'h1);
    apb(1'b1, mxu_pkg::OFS_PC, 32'h0);
    check({31'h0, err}, 32'h1);
    apb(1'b1, mxu_pkg::OFS_INSTR, {3'h0, 5'h1b, 24'h0});
    check({31'h0, err}, 32'h1);
    final_report();
  end
endmodule

bind mxu_exec_unit mxu_exec_chk chk_u (.clk_i, .resetn_i, .psel_i, .penable_i, .pwrite_i,
  .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .int_pending_i, .wake_i,
  .clk_run_o, .wdt_clear_o, .int_ack_o);
`default_nettype wire

// ===== verilog/mxu_exec_unit.sv
// instruction execute unit: accumulator, data memory, flags, pc and return stack
// assumes a synchronous apb master, synchronous wake and interrupt request inputs,
// and an outside watchdog and clock gate that obey wdt_clear_o and clk_run_o
//
// Contract
// RULE_01: complement writes inverted byte to memory or accumulator; only zero flag changes.
// RULE_02: decimal adjust adds 6 to low nibble when above 9 or aux carry set.
// RULE_03: decimal adjust adds 6 to high nibble when above 9 or carry set.
// RULE_04: decimal adjust writes result to memory and changes only the carry flag.
// RULE_05: decrement subtracts one into memory or accumulator; only zero flag changes.
// RULE_06: increment adds one into memory or accumulator; only zero flag changes.
// RULE_07: power-down stops fetching and executing and gates the system clock off.
// RULE_08: power-down keeps memory and registers and clears watchdog and prescaler.
// RULE_09: power-down sets the power-down flag and clears the watchdog time-out flag.
// RULE_10: jump loads pc with target, takes two cycles, changes no flag.
// RULE_11: moves copy memory or immediate to accumulator or accumulator to memory.
// RULE_12: or combines accumulator with memory or immediate; only zero flag changes.
// RULE_13: return pops pc from stack; immediate variant also loads the accumulator.
// RULE_14: interrupt return pops pc and sets the master interrupt enable.
// RULE_15: a pending interrupt at interrupt return is serviced before main program.
// RULE_16: rotate left moves bits up and bit 7 into bit 0; no flags.
// RULE_17: rotate left through carry: old carry into bit 0, bit 7 into carry.
// RULE_18: rotate right moves bits down and bit 0 into bit 7; no flags.
// RULE_19: rotate right through carry: old carry into bit 7, bit 0 into carry.
// RULE_20: rotates to the accumulator never write the memory byte.
// RULE_21: no-operation only advances the program counter.
// RULE_22: any instruction changing the pc low byte takes two instruction cycles.
// RULE_23: zero flag set when the 8-bit result is zero, cleared otherwise.
`default_nettype none
module mxu_exec_unit
(
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output var  logic [31:0] prdata_o,
  output var  logic        pready_o,
  output var  logic        pslverr_o,
  // system side
  input  wire logic        int_pending_i,
  input  wire logic        wake_i,
  output var  logic        clk_run_o,
  output var  logic        wdt_clear_o,
  output var  logic        int_ack_o
);
  // reset release through two flip-flops
  logic rst_meta_q;
  logic rst_sync_q;
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  wire logic rst_n = rst_sync_q;

  // zero test shared by every zero-flag update
  function automatic logic is_zero(input logic [7:0] v);
    is_zero = (v == 8'h00); // [RULE_23]
  endfunction

  // architectural state
  logic [7:0]  mem_q [mxu_pkg::MEM_WORDS];
  logic [7:0]  acc_q;
  logic [5:0]  flags_q;
  logic [9:0]  pc_q;
  logic [9:0]  stack_q [mxu_pkg::STACK_DEPTH];
  logic [1:0]  sp_q;
  logic [2:0]  depth_q;
  logic [31:0] ins_q;
  logic [5:0]  maddr_q;
  logic [1:0]  div_q;
  mxu_pkg::mxu_state_t state_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic        clk_run_q;
  logic        wdt_clear_q;
  logic        int_ack_q;

  // instruction decode
  mxu_pkg::mxu_op_t op;
  wire logic [7:0] opd   = ins_q[mxu_pkg::INS_OPD_LSB +: 8];
  wire logic [9:0] tgt   = ins_q[mxu_pkg::INS_TGT_LSB +: 10];
  wire logic [5:0] madr  = opd[5:0];
  wire logic [7:0] mval  = mem_q[madr];
  wire logic       c_in  = flags_q[mxu_pkg::FL_C];
  wire logic       ac_in = flags_q[mxu_pkg::FL_AC];
  assign op = mxu_pkg::mxu_op_t'(ins_q[mxu_pkg::INS_OP_LSB +: 5]);

  // decimal adjust correction terms
  wire logic       daa_lo  = (acc_q[3:0] > 4'h9) || ac_in;  // [RULE_02]
  wire logic       daa_hi  = (acc_q[7:4] > 4'h9) || c_in;   // [RULE_03]
  wire logic [7:0] daa_add = {1'b0, daa_hi, daa_hi, 1'b0, 1'b0, daa_lo, daa_lo, 1'b0};
  wire logic [8:0] daa_sum = {1'b0, acc_q} + {1'b0, daa_add};

  // instruction cycle divider; stopped while the clock is gated off
  wire logic tick = (div_q == mxu_pkg::TICK_LAST);

  // execution datapath
  logic [7:0] res;
  logic       wr_mem;
  logic       wr_acc;
  logic       upd_z;
  logic       upd_c;
  logic       c_new;
  logic       two_cyc;
  logic       do_pop;
  logic       do_jump;
  logic       do_halt;
  logic       do_iret;
  always_comb
  begin
    res     = 8'h00;
    wr_mem  = 1'b0;
    wr_acc  = 1'b0;
    upd_z   = 1'b0;
    upd_c   = 1'b0;
    c_new   = c_in;
    two_cyc = 1'b0;
    do_pop  = 1'b0;
    do_jump = 1'b0;
    do_halt = 1'b0;
    do_iret = 1'b0;
    case (op)
      mxu_pkg::OP_CPL_M:  begin res = ~mval; wr_mem = 1'b1; upd_z = 1'b1; end // [RULE_01]
      mxu_pkg::OP_CPL_A:  begin res = ~mval; wr_acc = 1'b1; upd_z = 1'b1; end // [RULE_01]
      mxu_pkg::OP_DAA:
      begin
        res    = daa_sum[7:0];
        wr_mem = 1'b1;                   // [RULE_04]
        upd_c  = 1'b1;
        c_new  = daa_hi | daa_sum[8];    // carry marks a decimal sum past 99 [RULE_04]
      end
      mxu_pkg::OP_DEC_M:  begin res = mval - 8'h01; wr_mem = 1'b1; upd_z = 1'b1; end // [RULE_05]
      mxu_pkg::OP_DEC_A:  begin res = mval - 8'h01; wr_acc = 1'b1; upd_z = 1'b1; end // [RULE_05]
      mxu_pkg::OP_INC_M:  begin res = mval + 8'h01; wr_mem = 1'b1; upd_z = 1'b1; end // [RULE_06]
      mxu_pkg::OP_INC_A:  begin res = mval + 8'h01; wr_acc = 1'b1; upd_z = 1'b1; end // [RULE_06]
      mxu_pkg::OP_JUMP:   begin do_jump = 1'b1; two_cyc = 1'b1; end // [RULE_10] [RULE_22]
      mxu_pkg::OP_MOV_AM: begin res = mval;  wr_acc = 1'b1; end // [RULE_11]
      mxu_pkg::OP_MOV_AX: begin res = opd;   wr_acc = 1'b1; end // [RULE_11]
      mxu_pkg::OP_MOV_MA: begin res = acc_q; wr_mem = 1'b1; end // [RULE_11]
      mxu_pkg::OP_OR_AM:  begin res = acc_q | mval; wr_acc = 1'b1; upd_z = 1'b1; end // [RULE_12]
      mxu_pkg::OP_OR_AX:  begin res = acc_q | opd;  wr_acc = 1'b1; upd_z = 1'b1; end // [RULE_12]
      mxu_pkg::OP_OR_M:   begin res = acc_q | mval; wr_mem = 1'b1; upd_z = 1'b1; end // [RULE_12]
      mxu_pkg::OP_RET:    begin do_pop = 1'b1; two_cyc = 1'b1; end // [RULE_13] [RULE_22]
      mxu_pkg::OP_RET_AX:
      begin
        res     = opd;
        wr_acc  = 1'b1;
        do_pop  = 1'b1;
        two_cyc = 1'b1; // [RULE_13] [RULE_22]
      end
      mxu_pkg::OP_IRET:   begin do_pop = 1'b1; do_iret = 1'b1; two_cyc = 1'b1; end // [RULE_22]
      mxu_pkg::OP_ROL_M:  begin res = {mval[6:0], mval[7]}; wr_mem = 1'b1; end // [RULE_16]
      mxu_pkg::OP_ROL_A:
      begin
        res = {mval[6:0], mval[7]}; wr_acc = 1'b1; // [RULE_16] [RULE_20]
      end
      mxu_pkg::OP_ROLC_M:
      begin
        res = {mval[6:0], c_in}; wr_mem = 1'b1; upd_c = 1'b1; c_new = mval[7]; // [RULE_17]
      end
      mxu_pkg::OP_ROLC_A:
      begin
        res = {mval[6:0], c_in}; wr_acc = 1'b1; // [RULE_17] [RULE_20]
        upd_c = 1'b1; c_new = mval[7]; // [RULE_17]
      end
      mxu_pkg::OP_ROR_M:  begin res = {mval[0], mval[7:1]}; wr_mem = 1'b1; end // [RULE_18]
      mxu_pkg::OP_ROR_A:
      begin
        res = {mval[0], mval[7:1]}; wr_acc = 1'b1; // [RULE_18] [RULE_20]
      end
      mxu_pkg::OP_RORC_M:
      begin
        res = {c_in, mval[7:1]}; wr_mem = 1'b1; upd_c = 1'b1; c_new = mval[0]; // [RULE_19]
      end
      mxu_pkg::OP_RORC_A:
      begin
        res = {c_in, mval[7:1]}; wr_acc = 1'b1; // [RULE_19] [RULE_20]
        upd_c = 1'b1; c_new = mval[0]; // [RULE_19]
      end
      mxu_pkg::OP_PWRDN:  begin do_halt = 1'b1; end
      default:            begin res = 8'h00; end // no-operation: pc advance only [RULE_21]
    endcase
  end

  // apb decode; registers may only be written while the core is idle
  wire logic setup    = psel_i && !penable_i;
  wire logic acc_edge = psel_i && penable_i && pready_q;
  wire logic idle     = (state_q == mxu_pkg::ST_IDLE);
  wire logic hit_ins  = (paddr_i == mxu_pkg::OFS_INSTR);
  wire logic hit_acc  = (paddr_i == mxu_pkg::OFS_ACC);
  wire logic hit_flg  = (paddr_i == mxu_pkg::OFS_FLAGS);
  wire logic hit_pc   = (paddr_i == mxu_pkg::OFS_PC);
  wire logic hit_mad  = (paddr_i == mxu_pkg::OFS_MADDR);
  wire logic hit_mdt  = (paddr_i == mxu_pkg::OFS_MDATA);
  wire logic hit_sts  = (paddr_i == mxu_pkg::OFS_STATUS);
  wire logic hit_stk  = (paddr_i == mxu_pkg::OFS_STACK);
  wire logic mapped   = hit_ins | hit_acc | hit_flg | hit_pc | hit_mad | hit_mdt
                        | hit_sts | hit_stk;
  wire logic wr_ro    = pwrite_i && (hit_pc || hit_sts);
  wire logic ins_ok   = (pwdata_i[mxu_pkg::INS_OP_LSB +: 5] <= 5'(mxu_pkg::OP_PWRDN));
  wire logic wr_bad   = pwrite_i && (!idle || (hit_ins && !ins_ok));
  wire logic err      = !mapped || wr_ro || wr_bad;
  wire logic wr_go    = acc_edge && pwrite_i && !pslverr_q;
  wire logic [31:0] rd_mux =
      hit_acc ? {24'h000000, acc_q} :
      hit_flg ? {26'h0, flags_q} :
      hit_pc  ? {22'h0, pc_q} :
      hit_mad ? {26'h0, maddr_q} :
      hit_mdt ? {24'h000000, mem_q[maddr_q]} :
      hit_sts ? {29'h0, clk_run_q, state_q} :
      hit_stk ? {29'h0, depth_q} :
      hit_ins ? ins_q : 32'h00000000;

  // answer registered in the setup cycle so pready is high in the first access cycle
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end
    else
    begin
      pready_q  <= setup;
      pslverr_q <= setup && err;
      prdata_q  <= (setup && !pwrite_i && mapped) ? rd_mux : 32'h00000000;
    end
  end

  // divider runs only while the system clock is enabled [RULE_07]
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      div_q <= 2'b00;
    else if (state_q == mxu_pkg::ST_HALTED)
      div_q <= 2'b00;
    else
      div_q <= div_q + 2'b01;
  end

  // sequencer, pc, stack, accumulator and flags
  wire logic fire  = (state_q == mxu_pkg::ST_EXEC) && tick;
  wire logic [1:0] sp_pop = sp_q - 2'b01;
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q     <= mxu_pkg::ST_IDLE;
      acc_q       <= mxu_pkg::ACC_RST;
      flags_q     <= mxu_pkg::FLAGS_RST;
      pc_q        <= mxu_pkg::PC_RST;
      sp_q        <= 2'b00;
      depth_q     <= 3'b000;
      ins_q       <= 32'h00000000;
      maddr_q     <= 6'h00;
      clk_run_q   <= 1'b1;
      wdt_clear_q <= 1'b0;
      int_ack_q   <= 1'b0;
    end
    else
    begin
      wdt_clear_q <= 1'b0;
      int_ack_q   <= 1'b0;
      case (state_q)
        mxu_pkg::ST_IDLE:
        begin
          if (wr_go && hit_ins)
          begin
            ins_q   <= pwdata_i;
            state_q <= mxu_pkg::ST_EXEC;
          end
          if (wr_go && hit_acc)
            acc_q <= pwdata_i[7:0];
          if (wr_go && hit_flg)
            flags_q <= pwdata_i[5:0];
          if (wr_go && hit_mad)
            maddr_q <= pwdata_i[5:0];
          if (wr_go && hit_stk)
          begin
            stack_q[sp_q] <= pwdata_i[9:0];
            sp_q          <= sp_q + 2'b01;
            depth_q       <= (depth_q == 3'(mxu_pkg::STACK_DEPTH)) ? depth_q : depth_q + 3'b001;
          end
        end
        mxu_pkg::ST_EXEC:
        begin
          if (fire)
          begin
            if (wr_acc)
              acc_q <= res;
            if (upd_z)
              flags_q[mxu_pkg::FL_Z] <= is_zero(res); // [RULE_23]
            if (upd_c)
              flags_q[mxu_pkg::FL_C] <= c_new;
            pc_q    <= pc_q + 10'h001;
            state_q <= two_cyc ? mxu_pkg::ST_DUMMY : mxu_pkg::ST_IDLE;
            if (do_jump)
              pc_q <= tgt; // [RULE_10]
            if (do_pop)
            begin
              pc_q    <= stack_q[sp_pop]; // [RULE_13] [RULE_14]
              sp_q    <= sp_pop;
              depth_q <= (depth_q == 3'b000) ? depth_q : depth_q - 3'b001;
            end
            if (do_iret)
              flags_q[mxu_pkg::FL_EMI] <= 1'b1; // [RULE_14]
            if (do_iret && int_pending_i)
            begin
              // return address stays stacked; service routine entry clears enable
              pc_q                     <= mxu_pkg::INT_VECTOR; // [RULE_15]
              sp_q                     <= sp_q;
              depth_q                  <= depth_q;
              flags_q[mxu_pkg::FL_EMI] <= 1'b0;
              int_ack_q                <= 1'b1; // [RULE_15]
            end
            if (do_halt)
            begin
              flags_q[mxu_pkg::FL_PDF] <= 1'b1; // [RULE_09]
              flags_q[mxu_pkg::FL_TO]  <= 1'b0; // [RULE_09]
              wdt_clear_q              <= 1'b1; // [RULE_08]
              clk_run_q                <= 1'b0; // [RULE_07]
              state_q                  <= mxu_pkg::ST_HALTED; // [RULE_07]
            end
          end
        end
        mxu_pkg::ST_DUMMY:
        begin
          if (tick)
            state_q <= mxu_pkg::ST_IDLE; // second instruction cycle [RULE_22]
        end
        mxu_pkg::ST_HALTED:
        begin
          // nothing is fetched or run; all state is held [RULE_07] [RULE_08]
          if (wake_i)
          begin
            clk_run_q <= 1'b1;
            state_q   <= mxu_pkg::ST_IDLE;
          end
        end
        default:
          state_q <= mxu_pkg::ST_IDLE;
      endcase
    end
  end

  // data memory has no reset; contents survive power-down [RULE_08]
  always_ff @(posedge clk_i)
  begin
    if (fire && wr_mem)
      mem_q[madr] <= res; // accumulator forms never reach here [RULE_20]
    else if (wr_go && hit_mdt)
      mem_q[maddr_q] <= pwdata_i[7:0];
  end

  assign prdata_o    = prdata_q;
  assign pready_o    = pready_q;
  assign pslverr_o   = pslverr_q;
  assign clk_run_o   = clk_run_q;
  assign wdt_clear_o = wdt_clear_q;
  assign int_ack_o   = int_ack_q;
endmodule
`default_nettype wire
